/* File: design/disk_csr_pkg.sv */
// Constants and carrier types for the disk control/status register block.
// Assumes a single 25 MHz clock domain and a 32-bit APB slave.
package disk_csr_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CSR_OFFSET    = 8'h00;
	localparam logic [7:0] FAULT_OFFSET  = 8'h04;
	localparam logic [7:0] IRQ_ST_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_MK_OFFSET = 8'h0C;

	// ==========================================================
	// Control/status field positions
	localparam int GO_BIT      = 0;
	localparam int FUNC_LSB    = 1;
	localparam int DONE_IRQ_BIT  = 6;
	localparam int RDY_BIT       = 7;
	localparam int STOP_SOFT_BIT = 8;
	localparam int SPARE_BIT     = 9;
	localparam int FORMAT_BIT    = 10;
	localparam int HOLD_BIT      = 11;
	localparam int UNUSED_BIT    = 12;
	localparam int SEARCH_BIT    = 13;
	localparam int HE_BIT      = 14;
	localparam int ERR_BIT     = 15;

	// Fault register: bits 05..15 are hard faults
	localparam logic [15:0] HARD_MASK = 16'hFFE0;
	localparam logic [15:0] CSR_RESET = 16'h0080;

	// Interrupt status bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_HARD  = 1;
	localparam int IRQ_SOFT  = 2;
	localparam int IRQ_SRCH  = 3;
	localparam int IRQ_W     = 4;

	// ==========================================================
	// Timing: go may wait up to 3.3 ms for the sequencer
	localparam int  CLK_MHZ      = 25;
	localparam int  GO_WAIT_US   = 3300;
	localparam int  GO_WAIT_CYC  = GO_WAIT_US * CLK_MHZ;

	// ==========================================================
	// Function codes
	typedef enum logic [2:0] {
		FN_CTRL_RESET  = 3'b000,
		FN_WRITE       = 3'b001,
		FN_READ        = 3'b010,
		FN_WRITE_CHECK = 3'b011,
		FN_SEEK        = 3'b100,
		FN_READ_CHECK  = 3'b101,
		FN_DRIVE_RESET = 3'b110,
		FN_WRITE_LOCK  = 3'b111
	} func_t;

	// Controls handed to the sequencer
	typedef struct packed {
		logic       start;
		func_t      func;
		logic       format_mode;
		logic       hold_address;
		logic       halt;
		logic       skip_cyl_check;
		logic       header_only;
	} seq_ctl_t;

	// Events from the sequencer and drive
	typedef struct packed {
		logic        begun;
		logic        done;
		logic        sector_end;
		logic        soft_fault;
		logic [15:0] fault_set;
	} seq_evt_t;

endpackage

/* File: design/disk_ctrl_status_upper.sv */
// Upper control/status bits of a moving-head disk controller, APB slave.
// Assumes a sequencer and drive interface providing pulse events on pclk.
`timescale 1ns/10ps

// Behaviour
// - Ready sets on init, hard fault or function end; clears on go.
// - Soft fault with stop option, no done-irq: halt at sector end silently.
// - Soft fault with stop option and done-irq: halt and interrupt at sector end.
// - Format-mode write skips the cylinder check but rewrites headers.
// - Format-mode read moves only one header word per sector.
// - Hold-address bit freezes the memory address counter.
// - Severe fault flag follows fault bits 05-15 and stops control activity.
// - Hard faults stay until init; a control reset cannot begin while one is set.
// - Error summary set while any fault bit set; clears when all clear.
// - Response to error summary depends on done-irq and stop options.
// - Go stays set until the controller begins the function.
module disk_ctrl_status_upper
	import disk_csr_pkg::*;
#(
	parameter int GO_TIMEOUT = disk_csr_pkg::GO_WAIT_CYC
) (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Sequencer side
	input  wire disk_csr_pkg::seq_evt_t  seq_evt,
	output disk_csr_pkg::seq_ctl_t       seq_ctl,
	output logic                         go_timeout,
	// Interrupt
	output logic                         irq
);
	import disk_csr_pkg::*;

	// ==========================================================
	// State
	logic                 go_ff;
	logic [2:0]           func_ff;
	logic [1:0]           ext_ff;
	logic                 done_irq_en_ff;
	logic                 rdy_ff;
	logic                 stop_soft_ff;
	logic                 spare_ff;
	logic                 format_ff;
	logic                 hold_ff;
	logic                 unused_ff;
	logic                 search_done_ff;
	logic                 hard_now;
	logic [15:0]          fault_ff;
	logic                 soft_pend_ff;
	logic                 halt_ff;
	logic                 search_fn_ff;
	logic [IRQ_W-1:0]     mask_ff;
	logic [IRQ_W-1:0]     irq_st;
	logic [31:0]          go_cnt_ff;
	logic                 bus_irq_ff;

	logic                 acc;
	logic                 wr;
	logic                 rd;
	logic                 wr_csr;
	logic                 ctrl_reset;
	logic                 he;
	logic                 err;
	logic                 soft_stop;
	logic [IRQ_W-1:0]     irq_set;
	logic [15:0]          csr_rd;

	assign acc        = psel && penable;
	assign wr         = acc && pwrite;
	assign rd         = acc && !pwrite;
	assign wr_csr     = wr && (paddr == CSR_OFFSET);
	assign ctrl_reset = seq_evt.begun && (func_ff == FN_CTRL_RESET);

	// Severe fault from upper fault bits
	assign he  = |(fault_ff & HARD_MASK);
	// Error summary tracks any fault bit
	assign err = |fault_ff;
	assign hard_now = |(seq_evt.fault_set & HARD_MASK);
	// Pending soft fault halts at sector end
	assign soft_stop = soft_pend_ff && seq_evt.sector_end;

	// ==========================================================
	// Control bits writable by software
	// Only writable fields load from the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_ff        <= 3'h0;
			ext_ff         <= 2'h0;
			done_irq_en_ff <= 1'b0;
			stop_soft_ff   <= 1'b0;
			spare_ff       <= 1'b0;
			format_ff      <= 1'b0;
			hold_ff        <= 1'b0;
			unused_ff      <= 1'b0;
		end else if (wr_csr) begin
			func_ff        <= pwdata[FUNC_LSB +: 3];
			ext_ff         <= pwdata[5:4];
			done_irq_en_ff <= pwdata[DONE_IRQ_BIT];
			stop_soft_ff   <= pwdata[STOP_SOFT_BIT];
			spare_ff       <= pwdata[SPARE_BIT];
			format_ff      <= pwdata[FORMAT_BIT];
			hold_ff   <= pwdata[HOLD_BIT];
			unused_ff <= pwdata[UNUSED_BIT];
		end
	end

	// ==========================================================
	// Go bit and its wait watchdog
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_ff <= 1'b0;
		end else if (wr_csr && pwdata[GO_BIT] && !he) begin
			go_ff <= 1'b1;
		// Go holds until the sequencer begins
		end else if (seq_evt.begun) begin
			go_ff <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_cnt_ff  <= 32'h0000_0000;
			go_timeout <= 1'b0;
		end else if (!go_ff) begin
			go_cnt_ff  <= 32'h0000_0000;
			go_timeout <= 1'b0;
		end else begin
			if (go_cnt_ff < GO_TIMEOUT) begin
				go_cnt_ff <= go_cnt_ff + 32'h0000_0001;
			end
			go_timeout <= (go_cnt_ff >= GO_TIMEOUT);
		end
	end

	// ==========================================================
	// Ready flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_ff <= 1'b1;
		// Set on hard fault or termination
		end else if (he || seq_evt.done || soft_stop) begin
			rdy_ff <= 1'b1;
		end else if (wr_csr && pwdata[GO_BIT]) begin
			rdy_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Fault register
	// Hard bits stick until init; control reset cannot begin while one is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff <= 16'h0000;
		end else if (ctrl_reset) begin
			fault_ff <= seq_evt.fault_set;
		end else begin
			fault_ff <= fault_ff | seq_evt.fault_set;
		end
	end

	// ==========================================================
	// Soft-fault stop and halt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_pend_ff <= 1'b0;
		end else if (seq_evt.soft_fault && stop_soft_ff) begin
			soft_pend_ff <= 1'b1;
		end else if (seq_evt.sector_end || seq_evt.begun) begin
			soft_pend_ff <= 1'b0;
		end
	end

	// Hard fault stops all control action
	// Stop at sector end after soft fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_ff <= 1'b0;
		end else if (he || soft_stop) begin
			halt_ff <= 1'b1;
		// New go lets software continue after a soft stop
		end else if (wr_csr && pwdata[GO_BIT]) begin
			halt_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Search complete
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			search_fn_ff <= 1'b0;
		end else if (seq_evt.begun) begin
			search_fn_ff <= (func_ff == FN_SEEK) || (func_ff == FN_DRIVE_RESET);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			search_done_ff <= 1'b0;
		// Set when seek or drive reset completes with interrupt
		end else if (seq_evt.done && search_fn_ff && done_irq_en_ff) begin
			search_done_ff <= 1'b1;
		// Cleared when a new function starts
		end else if (seq_evt.begun) begin
			search_done_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Sequencer controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_ctl <= '0;
		end else begin
			seq_ctl.start          <= go_ff && !seq_evt.begun && !halt_ff && !he && !hard_now;
			seq_ctl.func           <= func_t'(func_ff);
			seq_ctl.format_mode    <= format_ff;
			seq_ctl.hold_address   <= hold_ff;
			seq_ctl.halt           <= halt_ff || he || soft_stop || hard_now;
			seq_ctl.skip_cyl_check <= format_ff && (func_ff == FN_WRITE);
			seq_ctl.header_only    <= format_ff && (func_ff == FN_READ);
		end
	end

	// ==========================================================
	// Interrupt events
	// Soft stop raises request only with done-irq enabled
	// Error response gated by done-irq and stop options
	always_comb begin
		irq_set           = '0;
		irq_set[IRQ_DONE] = seq_evt.done && done_irq_en_ff;
		irq_set[IRQ_HARD] = hard_now && done_irq_en_ff;
		irq_set[IRQ_SOFT] = soft_stop && done_irq_en_ff;
		irq_set[IRQ_SRCH] = seq_evt.done && search_fn_ff && done_irq_en_ff;
	end

	sticky_flags #(
		.W (IRQ_W)
	) u_irq_flags (
		.pclk     (pclk),
		.presetn  (presetn),
		.set_in   (irq_set),
		.clr      (rd && (paddr == IRQ_ST_OFFSET)),
		.flags_ff (irq_st)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= '0;
		end else if (wr && (paddr == IRQ_MK_OFFSET)) begin
			mask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_irq_ff <= 1'b0;
		end else begin
			bus_irq_ff <= |(irq_st & mask_ff);
		end
	end
	assign irq = bus_irq_ff;

	// ==========================================================
	// APB read path
	always_comb begin
		csr_rd             = 16'h0000;
		csr_rd[FUNC_LSB+:3] = func_ff;
		csr_rd[5:4]        = ext_ff;
		csr_rd[DONE_IRQ_BIT]  = done_irq_en_ff;
		csr_rd[RDY_BIT]       = rdy_ff;
		csr_rd[STOP_SOFT_BIT] = stop_soft_ff;
		csr_rd[SPARE_BIT]     = spare_ff;
		csr_rd[FORMAT_BIT]    = format_ff;
		csr_rd[HOLD_BIT]      = hold_ff;
		csr_rd[UNUSED_BIT]    = unused_ff;
		csr_rd[SEARCH_BIT]    = search_done_ff;
		csr_rd[HE_BIT]     = he;
		csr_rd[ERR_BIT]    = err;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				unique case (paddr)
					CSR_OFFSET:    prdata <= {16'h0000, csr_rd};
					FAULT_OFFSET:  prdata <= {16'h0000, fault_ff};
					IRQ_ST_OFFSET: prdata <= {28'h000_0000, irq_st};
					IRQ_MK_OFFSET: prdata <= {28'h000_0000, mask_ff};
					default:       pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule // disk_ctrl_status_upper

/* File: design/sticky_flags.sv */
// Sticky event flags, cleared by a read, with set winning over clear.
// Assumes synchronous event pulses on pclk.
`timescale 1ns/10ps
module sticky_flags #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Events and clear
	input  wire logic [W-1:0] set_in,
	input  wire logic         clr,
	// State
	output logic      [W-1:0] flags_ff
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (clr ? '0 : flags_ff) | set_in;
		end
	end
endmodule // sticky_flags

/* File: test/disk_csr_asserts.sv */
// Checker for the disk control/status register block.
// Assumes it is bound onto the top module; one pclk domain.
`timescale 1ns/10ps
module disk_csr_asserts
	import disk_csr_pkg::*;
(
	// Clock, reset and APB
	input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	// Sequencer side
	input wire disk_csr_pkg::seq_evt_t seq_evt,
	input wire disk_csr_pkg::seq_ctl_t seq_ctl
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Bus timing
	property p_answer; psel && !penable |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("no answer after setup");
	property p_pulse; pready |-> psel && penable ##1 !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready outside one access cycle");
	property p_err; pready && paddr > 8'h0C |-> pslverr && prdata == 32'h0000_0000; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok; pready && paddr <= 8'h0C |-> !pslverr && prdata[31:16] == 16'h0000; endproperty
	a_ok: assert property (p_ok)
		else $error("mapped access refused or upper bits set");
	// ==========================================================
	// Control outputs
	property p_skip; seq_ctl.skip_cyl_check == (seq_ctl.format_mode && seq_ctl.func == FN_WRITE);
	endproperty
	a_skip: assert property (p_skip)
		else $error("cylinder check skip wrong");
	property p_hdr; seq_ctl.header_only == (seq_ctl.format_mode && seq_ctl.func == FN_READ);
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("header only wrong");
	property p_halt; |seq_evt.fault_set[15:5] |=> seq_ctl.halt && !seq_ctl.start; endproperty
	a_halt: assert property (p_halt)
		else $error("hard fault did not halt");
	property p_go; seq_ctl.start && !seq_evt.begun && !psel && seq_evt.fault_set == 16'h0000
		|=> seq_ctl.start; endproperty
	a_go: assert property (p_go)
		else $error("go dropped before begin");
	property p_rdy; pready && !pwrite && paddr == CSR_OFFSET && $past(seq_ctl.start)
		&& !seq_ctl.halt |-> !prdata[RDY_BIT]; endproperty
	a_rdy: assert property (p_rdy)
		else $error("ready set while go pending");
endmodule // disk_csr_asserts
bind disk_ctrl_status_upper disk_csr_asserts chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.paddr(paddr), .prdata(prdata), .seq_evt(seq_evt), .seq_ctl(seq_ctl));

/* File: test/disk_seq_model.sv */
// Sequencer and drive model: begins after lat cycles, one sector, then done.
// Assumes the bench drives lat and fault injections on pclk.
`timescale 1ns/10ps
module disk_seq_model
	import disk_csr_pkg::*;
(
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// Controller side
	input  wire disk_csr_pkg::seq_ctl_t seq_ctl,
	output disk_csr_pkg::seq_evt_t      seq_evt,
	// Bench controls
	input  wire logic [7:0]             lat,
	input  wire logic                   inj_soft,
	input  wire logic [15:0]            inj_fault
);
	logic [7:0] cnt_ff;
	logic       busy_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff  <= 8'h00;
			busy_ff <= 1'b0;
		end else if (busy_ff) begin
			cnt_ff  <= (cnt_ff == 8'h04 || seq_ctl.halt) ? 8'h00 : cnt_ff + 8'h01;
			busy_ff <= !(cnt_ff == 8'h04 || seq_ctl.halt);
		end else if (seq_ctl.start) begin
			cnt_ff  <= (cnt_ff == lat) ? 8'h00 : cnt_ff + 8'h01;
			busy_ff <= (cnt_ff == lat);
		end
	end
	assign seq_evt = '{begun:      seq_ctl.start && !busy_ff && cnt_ff == lat,
	                   done:       busy_ff && cnt_ff == 8'h04 && !seq_ctl.halt,
	                   sector_end: busy_ff && cnt_ff == 8'h02,
	                   soft_fault: inj_soft,
	                   fault_set:  inj_fault};
endmodule // disk_seq_model

/* File: test/test_disk_ctrl_status_upper.sv */
// Self-checking bench for the disk control/status register block.
// Assumes the sequencer model and the bound checker.
`timescale 1ns/10ps
module test_disk_ctrl_status_upper;
	import disk_csr_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go_timeout, irq;
	logic        inj_soft, slv;
	logic [7:0]  paddr, lat;
	logic [15:0] inj_fault;
	logic [31:0] pwdata, prdata, rd;
	seq_evt_t    seq_evt;
	seq_ctl_t    seq_ctl;
	int          fail_count, comparisons;
	disk_ctrl_status_upper #(.GO_TIMEOUT(20)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_evt(seq_evt),
		.seq_ctl(seq_ctl), .go_timeout(go_timeout), .irq(irq));
	disk_seq_model seq_u (.pclk(pclk), .presetn(presetn), .seq_ctl(seq_ctl),
		.seq_evt(seq_evt), .lat(lat), .inj_soft(inj_soft), .inj_fault(inj_fault));
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50) begin
			fail_count++;
			give_verdict();
		end
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic poll_ready();
		int n;
		n = 0;
		do apb(0, CSR_OFFSET, 0); while (rd[RDY_BIT] !== 1'b1 && ++n < 60);
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		apb(0, CSR_OFFSET, 0); chk(rd, 32'h0000_0080);
		apb(1, CSR_OFFSET, 32'h0000_E080);
		apb(0, CSR_OFFSET, 0); chk(rd & 32'h0000_E080, 32'h0000_0080);
		apb(1, FAULT_OFFSET, 32'h0000_FFFF);
		apb(0, FAULT_OFFSET, 0); chk(rd, 32'h0000_0000);
		apb(0, 8'h10, 0); chk(rd, 32'h0000_0000);
		chk({31'h0, slv}, 32'h0000_0001);
		$display("regs test done");
	endtask
	task automatic t_read();
		lat <= 8'h0A;
		apb(1, IRQ_MK_OFFSET, 0);
		apb(1, CSR_OFFSET, 32'h0000_0C45);
		repeat (2) @(posedge pclk);
		chk({seq_ctl.start, seq_ctl.header_only, seq_ctl.hold_address}, 3'b111);
		apb(0, CSR_OFFSET, 0); chk(rd[RDY_BIT], 1'b0);
		poll_ready(); chk(irq, 1'b0);
		apb(1, IRQ_MK_OFFSET, 32'h0000_000F);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		apb(0, IRQ_ST_OFFSET, 0); chk(rd & 32'h0000_0001, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		$display("read test done");
	endtask
	task automatic t_seek();
		lat <= 8'd30;
		apb(1, CSR_OFFSET, 32'h0000_0049);
		repeat (25) @(posedge pclk);
		chk({go_timeout, seq_ctl.start}, 2'b11);
		poll_ready();
		chk(rd[SEARCH_BIT], 1'b1);
		lat <= 8'h03;
		apb(1, CSR_OFFSET, 32'h0000_0403);
		repeat (2) @(posedge pclk);
		chk(seq_ctl.skip_cyl_check, 1'b1);
		poll_ready(); chk(rd[SEARCH_BIT], 1'b0);
		$display("seek test done");
	endtask
	task automatic t_soft();
		int n;
		n = 0;
		apb(0, IRQ_ST_OFFSET, 0);
		apb(1, CSR_OFFSET, 32'h0000_0105);
		while (seq_evt.begun !== 1'b1 && ++n < 60) @(posedge pclk);
		inj_soft <= 1'b1;
		inj_fault <= 16'h0001;
		@(posedge pclk);
		inj_soft <= 1'b0;
		inj_fault <= 16'h0000;
		poll_ready();
		chk(rd & 32'h0000_E080, 32'h0000_8080);
		chk({seq_ctl.halt, irq}, 2'b10);
		$display("soft test done");
	endtask
	task automatic t_hard();
		do_reset();
		apb(0, CSR_OFFSET, 0); chk(rd & 32'h0000_E080, 32'h0000_0080);
		inj_fault <= 16'h0020;
		@(posedge pclk);
		inj_fault <= 16'h0000;
		apb(1, CSR_OFFSET, 32'h0000_0003);
		apb(0, CSR_OFFSET, 0); chk(rd & 32'h0000_E080, 32'h0000_C080);
		chk(seq_ctl.start, 1'b0);
		apb(0, FAULT_OFFSET, 0); chk(rd, 32'h0000_0020);
		do_reset();
		apb(0, FAULT_OFFSET, 0); chk(rd, 32'h0000_0000);
		$display("hard test done");
	endtask
	// ==========================================================
	// Clock, sequence and watchdog
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, inj_soft} = 5'b00000;
		{paddr, lat, inj_fault, pwdata} = '0;
		fail_count = 0;
		comparisons = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_read();
		t_seek();
		t_soft();
		t_hard();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		give_verdict();
	end
endmodule // test_disk_ctrl_status_upper
